// ==== design/operating_mode_controller.sv ====
// operating-mode controller: run, idle, slow, gated idle, stop and warm-up
// assumes cpu strobes synchronous to i_clk, pins already synchronised
`timescale 1ns/100ps
// Summary of operation
// R1: fast idle dual halts cpu and watchdog, returns to fast run dual
// R2: slow idle fast-osc-off halts cpu, watchdog, fast osc; returns slow off
// R3: slow off run and idle stop the low divider stages one to six
// R4: slow idle fast-osc-on equals slow idle off but fast osc runs
// R5: timing-gen halt bit in slow run enters gated slow idle
// R6: gated idle ends on falling edge of selected time-base tap
// R7: gated idle ignores time-base enable; irq taken only when all enabled
// R8: time-base enabled at gated entry sets irq latch after return
// R9: stop turns oscillators off, halts everything, keeps state
// R10: stop bit write starts stop; stop pin releases; resume after warm-up
// R11: release-method bit 0 edge release, 1 level release
// R12: return-mode bit 0 fast run, 1 slow run fast osc off
// R13: output-hold bit 0 ports high impedance in stop, 1 keep driving
// R14: software sets return-mode bit to match the mode it stops from
// R15: reset ends stop and returns to single-clock fast run
// R16: stop control bits 0 and 1 read undefined
// R17: output-hold 0 in stop forces port inputs to zero
// R18: key wakeup release needs level release method
// R19: rising-edge stop release must not enable key wakeup sources
// R20: stop puts the shared stop pin port into high impedance
// R21: machine cycle lasts four main system clock periods
// R22: non-gated idle release clears the cpu-halt bit
// R23: gated idle release clears the timing-gen halt bit
// R24: warm-up count selected by two-bit field holds operation
// R25: mode tracked by state machine moved by writes, wakes, reset
module operating_mode_controller import opmode_pkg::*; #(
  parameter int warm_fast0 = warm_fast0_cyc,
  parameter int warm_fast1 = warm_fast1_cyc,
  parameter int warm_fast2 = warm_fast2_cyc,
  parameter int warm_fast3 = warm_fast3_cyc,
  parameter int warm_slow0 = warm_slow0_cyc,
  parameter int warm_slow_run_fastosc_off = warm_slow_run_fastosc_off_cyc,
  parameter int warm_slow_run_fastosc_on = warm_slow_run_fastosc_on_cyc,
  parameter int warm_slow3 = warm_slow3_cyc
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_stop_pin,
  input wire logic i_key_wake,
  input wire logic i_wake_irq,
  input wire logic [3:0] i_tb_taps,
  input wire logic i_master_int_en,
  input wire logic i_tb_irq_en,
  output logic o_cpu_halt,
  output logic o_wdt_halt,
  output logic o_periph_clk_en,
  output logic o_tbt_clk_en,
  output logic o_fast_osc_en,
  output logic o_slow_osc_en,
  output logic o_main_clk_slow,
  output logic o_div_low_stop,
  output logic o_port_hiz,
  output logic o_port_in_zero,
  output logic o_shared_pin_hiz,
  output logic o_tb_irq_set,
  output logic o_tb_irq_take,
  output logic o_mcycle_tick,
  output logic [11:0] o_mode
);
  // ==========================================================
  // helpers
  function automatic mode_t run_of(input logic [7:0] c);
    if (!c[sysck_bit]) begin
      run_of = c[xten_bit] ? fast_run_dual : fast_run_single;
    end else begin
      run_of = c[xen_bit] ? slow_run_fastosc_on : slow_run_fastosc_off;
    end
  endfunction

  function automatic logic [26:0] warm_of(input logic [1:0] w,
                                          input logic slow);
    logic [31:0] v;
    v = 32'h0;
    case ({slow, w})
      3'h0: v = warm_fast0;
      3'h1: v = warm_fast1;
      3'h2: v = warm_fast2;
      3'h3: v = warm_fast3;
      3'h4: v = warm_slow0;
      3'h5: v = warm_slow_run_fastosc_off;
      3'h6: v = warm_slow_run_fastosc_on;
      default: v = warm_slow3;
    endcase
    warm_of = v[26:0];
  endfunction

  // ==========================================================
  // state
  mode_t state_reg, state_next;
  logic [7:0] stop_ctrl_reg, stop_ctrl_next;
  logic [7:0] clk_ctrl_reg, clk_ctrl_next;
  logic [7:0] tb_ctrl_reg, tb_ctrl_next;
  logic [26:0] warm_reg, warm_next;
  logic [1:0] mc_reg;
  logic pin_prev_reg, tap_prev_reg, tben_entry_reg;

  // ==========================================================
  // decode
  wire wr_stop = i_wr && i_addr == addr_stop_ctrl;
  wire wr_clk = i_wr && i_addr == addr_clk_ctrl;
  wire wr_tb = i_wr && i_addr == addr_tb_ctrl;
  wire release_method_bit = stop_ctrl_reg[release_method_bit_bit];
  wire return_mode_bit = stop_ctrl_reg[return_mode_bit_bit];
  wire stop_output_hold_bit = stop_ctrl_reg[stop_output_hold_bit_bit];
  wire [1:0] warmup_select = stop_ctrl_reg[wut_lsb +: 2];
  wire [1:0] tbck = tb_ctrl_reg[tbck_lsb +: 2];
  wire tben = tb_ctrl_reg[tben_bit];
  wire tap_now = i_tb_taps[tbck];
  wire tb_fall = tap_prev_reg && !tap_now; // R6
  wire edge_rel = i_stop_pin && !pin_prev_reg; // R11
  wire level_rel = i_stop_pin || i_key_wake; // R11
  wire release_ev = release_method_bit ? level_rel : edge_rel; // R10
  wire is_run = state_reg inside {fast_run_single, fast_run_dual,
    slow_run_fastosc_on, slow_run_fastosc_off};
  wire is_idle = state_reg inside {fast_idle_single, fast_idle_dual,
    slow_idle_fastosc_on, slow_idle_fastosc_off};
  wire is_gated = state_reg inside {gated_fast_idle, gated_slow_idle};
  wire is_slow = state_reg inside {slow_run_fastosc_on,
    slow_run_fastosc_off, slow_idle_fastosc_on, slow_idle_fastosc_off,
    gated_slow_idle};
  wire idle_exit = is_idle && i_wake_irq; // R22
  wire gated_exit = is_gated && tb_fall; // R23
  // last count cycle returns, so warm-up lasts exactly the loaded count
  wire warm_done = state_reg == warmup_mode && warm_reg <= 27'h1;
  wire start_stop = is_run && stop_ctrl_reg[stop_bit]; // R10
  wire in_stop = state_reg inside {stop_mode, warmup_mode};

  // ==========================================================
  // mode machine
  always_comb begin
    state_next = state_reg;
    warm_next = warm_reg;
    case (state_reg)
      fast_run_single, fast_run_dual,
      slow_run_fastosc_on, slow_run_fastosc_off: begin
        if (start_stop) begin
          // level release with pin already high skips stop_mode and goes straight to warm-up
          state_next = (release_method_bit && i_stop_pin) ? warmup_mode : stop_mode;
          warm_next = warm_of(warmup_select, return_mode_bit); // R24
        end else if (clk_ctrl_reg[timing_gen_halt_bit_bit]) begin
          state_next = clk_ctrl_reg[sysck_bit] ? gated_slow_idle
                                               : gated_fast_idle; // R5
        end else if (clk_ctrl_reg[idle_bit]) begin
          case (state_reg)
            fast_run_single: state_next = fast_idle_single;
            fast_run_dual: state_next = fast_idle_dual; // R1
            slow_run_fastosc_on: state_next = slow_idle_fastosc_on; // R4
            default: state_next = slow_idle_fastosc_off; // R2
          endcase
        end else begin
          state_next = run_of(clk_ctrl_reg); // R25
        end
      end
      fast_idle_single, fast_idle_dual,
      slow_idle_fastosc_on, slow_idle_fastosc_off: begin
        if (i_wake_irq) begin
          state_next = run_of(clk_ctrl_reg); // R1 R2 R4
        end
      end
      gated_fast_idle: begin
        if (tb_fall) begin
          state_next = run_of(clk_ctrl_reg);
        end
      end
      gated_slow_idle: begin
        if (tb_fall) begin
          state_next = slow_run_fastosc_off; // R6
        end
      end
      stop_mode: begin
        if (release_ev) begin
          state_next = warmup_mode; // R10
        end
      end
      warmup_mode: begin
        if (warm_reg <= 27'h1) begin
          // R12
          state_next = return_mode_bit ? slow_run_fastosc_off : run_of(clk_ctrl_next);
        end else begin
          warm_next = warm_reg - 27'h1; // R24
        end
      end
      default: state_next = fast_run_single;
    endcase
  end

  // ==========================================================
  // register next values, hardware effects beside software writes
  always_comb begin
    stop_ctrl_next = stop_ctrl_reg;
    clk_ctrl_next = clk_ctrl_reg;
    tb_ctrl_next = tb_ctrl_reg;
    if (wr_stop) begin
      stop_ctrl_next = i_wdata & stop_ctrl_mask;
    end
    if (wr_clk) begin
      clk_ctrl_next = i_wdata & clk_ctrl_mask;
    end
    if (wr_tb) begin
      tb_ctrl_next = i_wdata & tb_ctrl_mask;
    end
    if (idle_exit) begin
      clk_ctrl_next[idle_bit] = 1'b0; // R22
    end
    if (gated_exit) begin
      clk_ctrl_next[timing_gen_halt_bit_bit] = 1'b0; // R23
      if (state_reg == gated_slow_idle) begin
        clk_ctrl_next[xen_bit] = 1'b0; // R6
      end
    end
    if (warm_done) begin
      stop_ctrl_next[stop_bit] = 1'b0;
      clk_ctrl_next[sysck_bit] = return_mode_bit; // R12
      if (return_mode_bit) begin
        clk_ctrl_next[xen_bit] = 1'b0;
      end
    end
  end

  // ==========================================================
  // read mux; bits 1:0 of stop control are stored as zero
  logic [7:0] rd_mux;
  assign rd_mux = (i_addr == addr_stop_ctrl) ? stop_ctrl_reg : // R16
                  (i_addr == addr_clk_ctrl) ? clk_ctrl_reg :
                  (i_addr == addr_tb_ctrl) ? tb_ctrl_reg :
                  (i_addr == addr_mode_stat) ? {4'h0, state_reg[11:8]} |
                    {7'h0, |state_reg[7:0]} : 8'h00;

  // ==========================================================
  // output decode
  wire n_stop = state_next inside {stop_mode, warmup_mode};
  wire n_halt = !(state_next inside {fast_run_single, fast_run_dual,
    slow_run_fastosc_on, slow_run_fastosc_off});
  wire n_gated = state_next inside {gated_fast_idle, gated_slow_idle};
  wire n_slow_off = state_next inside {slow_run_fastosc_off,
    slow_idle_fastosc_off, gated_slow_idle};
  wire n_fast_osc = !n_slow_off &&
    !(state_next == stop_mode) &&
    !(state_next == warmup_mode && return_mode_bit); // R9
  wire n_slow_osc = clk_ctrl_next[xten_bit] &&
    !(state_next == stop_mode); // R9
  wire n_slow_clk = state_next inside {slow_run_fastosc_on,
    slow_run_fastosc_off, slow_idle_fastosc_on, slow_idle_fastosc_off,
    gated_slow_idle};

  // ==========================================================
  // sequential
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= fast_run_single; // R15
      stop_ctrl_reg <= stop_ctrl_rst;
      clk_ctrl_reg <= clk_ctrl_rst;
      tb_ctrl_reg <= tb_ctrl_rst;
      warm_reg <= 27'h0;
      mc_reg <= 2'h0;
      pin_prev_reg <= 1'b0;
      tap_prev_reg <= 1'b0;
      tben_entry_reg <= 1'b0;
      o_rdata <= 8'h00;
      o_cpu_halt <= 1'b0;
      o_wdt_halt <= 1'b0;
      o_periph_clk_en <= 1'b1;
      o_tbt_clk_en <= 1'b1;
      o_fast_osc_en <= 1'b1;
      o_slow_osc_en <= 1'b0;
      o_main_clk_slow <= 1'b0;
      o_div_low_stop <= 1'b0;
      o_port_hiz <= 1'b0;
      o_port_in_zero <= 1'b0;
      o_shared_pin_hiz <= 1'b0;
      o_tb_irq_set <= 1'b0;
      o_tb_irq_take <= 1'b0;
      o_mcycle_tick <= 1'b0;
      o_mode <= 12'h001;
    end else if (i_ce) begin
      state_reg <= state_next;
      stop_ctrl_reg <= stop_ctrl_next;
      clk_ctrl_reg <= clk_ctrl_next;
      tb_ctrl_reg <= tb_ctrl_next;
      warm_reg <= warm_next;
      pin_prev_reg <= i_stop_pin;
      tap_prev_reg <= tap_now;
      if (is_run && clk_ctrl_reg[timing_gen_halt_bit_bit]) begin
        tben_entry_reg <= tben; // R7
      end
      // machine cycle counts only while the cpu runs
      mc_reg <= n_halt ? 2'h0 : mc_reg + 2'h1; // R21
      o_mcycle_tick <= !n_halt && mc_reg == 2'(mcycle_states - 1); // R21
      o_rdata <= i_rd ? rd_mux : 8'h00;
      o_cpu_halt <= n_halt;
      o_wdt_halt <= n_halt; // R1 R2
      o_periph_clk_en <= !n_gated && !n_stop; // R5 R9
      o_tbt_clk_en <= !n_stop; // R5
      o_fast_osc_en <= n_fast_osc; // R2 R4
      o_slow_osc_en <= n_slow_osc;
      o_main_clk_slow <= n_slow_clk;
      o_div_low_stop <= n_slow_off; // R3
      o_port_hiz <= n_stop && !stop_output_hold_bit; // R13
      o_port_in_zero <= n_stop && !stop_output_hold_bit; // R17
      o_shared_pin_hiz <= n_stop; // R20
      o_tb_irq_set <= gated_exit && tben_entry_reg; // R8
      o_tb_irq_take <= i_master_int_en && i_tb_irq_en && tben; // R7
      o_mode <= state_next;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_stop_pin_hiz: assert property (state_reg == stop_mode |->
    o_shared_pin_hiz) else $error("shared pin driven in stop"); // R20
  a_stop_port_hold: assert property (state_reg == stop_mode |->
    o_port_hiz == !stop_output_hold_bit && o_port_in_zero == !stop_output_hold_bit)
    else $error("port hold wrong in stop"); // R13
  a_stop_osc_off: assert property (state_reg == stop_mode |->
    !o_fast_osc_en && !o_slow_osc_en && o_cpu_halt)
    else $error("stop left clocks running"); // R9
  a_edge_release: assert property (i_ce && state_reg == stop_mode &&
    !release_method_bit && i_stop_pin && !pin_prev_reg |=> state_reg == warmup_mode)
    else $error("edge release missed"); // R11
  a_level_release: assert property (i_ce && state_reg == stop_mode &&
    release_method_bit && $rose(i_key_wake) |=> state_reg == warmup_mode)
    else $error("level release missed"); // R11 R18
  a_gated_slow_exit: assert property (i_ce &&
    state_reg == gated_slow_idle && tb_fall |=>
    state_reg == slow_run_fastosc_off && !clk_ctrl_reg[timing_gen_halt_bit_bit])
    else $error("gated exit wrong"); // R6
  a_slow_div_stop: assert property (state_reg == slow_idle_fastosc_off
    |-> o_div_low_stop && !o_fast_osc_en)
    else $error("low divider not stopped"); // R3
  a_idle_clear: assert property (i_ce && is_idle && i_wake_irq |=>
    !clk_ctrl_reg[idle_bit] && o_cpu_halt == 1'b0)
    else $error("idle bit not cleared"); // R22
  a_tb_latch_set: assert property (i_ce && gated_exit &&
    tben_entry_reg |=> o_tb_irq_set)
    else $error("time base latch not set"); // R8
  a_warm_return: assert property (i_ce && warm_done && return_mode_bit |=>
    state_reg == slow_run_fastosc_off)
    else $error("wrong return mode"); // R12
  a_mode_onehot: assert property ($onehot(state_reg))
    else $error("mode not one-hot"); // R25

  c_stop_cycle: cover property (state_reg == stop_mode ##[1:20]
    state_reg == warmup_mode);
  c_gated_slow: cover property (state_reg == gated_slow_idle ##1
    state_reg == slow_run_fastosc_off);
  c_idle_dual: cover property (state_reg == fast_idle_dual ##1
    state_reg == fast_run_dual);
endmodule

// ==== design/opmode_pkg.sv ====
// constants, register map and mode encoding of the operating-mode controller
// assumes one main system clock at 125 MHz and a synchronous chip reset
package opmode_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] addr_stop_ctrl = 16'h0038;
  localparam logic [15:0] addr_clk_ctrl = 16'h0039;
  localparam logic [15:0] addr_tb_ctrl = 16'h0036;
  localparam logic [15:0] addr_mode_stat = 16'h003a;
  // ==========================================================
  // stop_mode_control fields
  localparam int stop_bit = 7;
  localparam int release_method_bit_bit = 6;
  localparam int return_mode_bit_bit = 5;
  localparam int stop_output_hold_bit_bit = 4;
  localparam int wut_lsb = 2;
  localparam logic [7:0] stop_ctrl_rst = 8'h00;
  localparam logic [7:0] stop_ctrl_mask = 8'hfc;
  // ==========================================================
  // clock_mode_control fields
  localparam int xen_bit = 7;
  localparam int xten_bit = 6;
  localparam int sysck_bit = 5;
  localparam int idle_bit = 4;
  localparam int timing_gen_halt_bit_bit = 2;
  localparam logic [7:0] clk_ctrl_rst = 8'h80;
  localparam logic [7:0] clk_ctrl_mask = 8'hf4;
  // ==========================================================
  // time_base_control fields
  localparam int tben_bit = 7;
  localparam int tbck_lsb = 0;
  localparam logic [7:0] tb_ctrl_rst = 8'h00;
  localparam logic [7:0] tb_ctrl_mask = 8'h83;
  // ==========================================================
  // timing
  localparam int clk_mhz = 125;
  localparam int mcycle_states = 4;
  localparam int warm_fast0_us = 12288;
  localparam int warm_fast1_us = 4096;
  localparam int warm_fast2_us = 1024;
  localparam int warm_fast3_us = 256;
  localparam int warm_slow0_us = 750000;
  localparam int warm_slow_run_fastosc_off_us = 250000;
  localparam int warm_slow_run_fastosc_on_us = 62500;
  localparam int warm_slow3_us = 15625;
  localparam int warm_fast0_cyc = warm_fast0_us * clk_mhz;
  localparam int warm_fast1_cyc = warm_fast1_us * clk_mhz;
  localparam int warm_fast2_cyc = warm_fast2_us * clk_mhz;
  localparam int warm_fast3_cyc = warm_fast3_us * clk_mhz;
  localparam int warm_slow0_cyc = warm_slow0_us * clk_mhz;
  localparam int warm_slow_run_fastosc_off_cyc = warm_slow_run_fastosc_off_us * clk_mhz;
  localparam int warm_slow_run_fastosc_on_cyc = warm_slow_run_fastosc_on_us * clk_mhz;
  localparam int warm_slow3_cyc = warm_slow3_us * clk_mhz;
  // ==========================================================
  // operating modes
  typedef enum logic [11:0] {
    fast_run_single = 12'h001,
    fast_run_dual = 12'h002,
    fast_idle_single = 12'h004,
    fast_idle_dual = 12'h008,
    gated_fast_idle = 12'h010,
    slow_run_fastosc_on = 12'h020,
    slow_run_fastosc_off = 12'h040,
    slow_idle_fastosc_on = 12'h080,
    slow_idle_fastosc_off = 12'h100,
    gated_slow_idle = 12'h200,
    stop_mode = 12'h400,
    warmup_mode = 12'h800
  } mode_t;
endpackage

// ==== tb/wake_side_model.sv ====
// far side of the block: stop pin, key wakeup line and time-base taps
// assumes bench commands change just after a rising edge of i_clk
`timescale 1ns/100ps
module wake_side_model #(
  parameter int pin_delay = 3
) (
  input wire logic i_clk,
  input wire logic i_pin_level,
  input wire logic i_key_level,
  input wire logic i_key_allowed,
  output logic o_stop_pin,
  output logic o_key_wake,
  output logic [3:0] o_taps
);
  // ==========================================================
  // pin delays and free-running tap sources
  logic [7:0] tap_reg = 8'h00;
  logic [7:0] pin_reg = 8'h00;
  logic [7:0] key_reg = 8'h00;
  // taps run on through stop, unlike the slow source oscillator, which stop turns off
  always @(posedge i_clk) begin
    tap_reg <= tap_reg + 8'h01;
    pin_reg <= {pin_reg[6:0], i_pin_level};
    // key wakeup only offered in level release mode
    key_reg <= {key_reg[6:0], i_key_level & i_key_allowed};
  end
  assign o_stop_pin = pin_reg[pin_delay-1];
  assign o_key_wake = key_reg[pin_delay-1];
  // slow taps so that a gated idle entry never races the first fall
  assign o_taps = tap_reg[7:4];
endmodule

// ==== tb/operating_mode_controller_tb_top.sv ====
// self-checking bench of the operating-mode controller
// assumes wake_side_model as far side and shortened warm-up counts
`timescale 1ns/100ps
module operating_mode_controller_tb_top import opmode_pkg::*;;
  localparam int warm_tab [8] = '{5, 7, 9, 11, 13, 15, 17, 19};
  typedef struct {string nm; int sel; logic [15:0] m; logic [15:0] e;} note_t;
  logic i_clk, i_rst_n, i_ce, i_wr, i_rd, i_wake_irq, i_master_int_en;
  logic i_tb_irq_en, i_stop_pin, i_key_wake;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic [3:0] i_tb_taps;
  logic o_cpu_halt, o_wdt_halt, o_periph_clk_en, o_tbt_clk_en;
  logic o_fast_osc_en, o_slow_osc_en, o_main_clk_slow, o_div_low_stop;
  logic o_port_hiz, o_port_in_zero, o_shared_pin_hiz, o_tb_irq_set;
  logic o_tb_irq_take, o_mcycle_tick;
  logic [11:0] o_mode, flags;
  logic pin_level, key_level, key_allowed, peek, rd_q;
  logic [2:0] tap_hist;
  logic [15:0] seen;
  int bad_count, checks_done, irq_cnt, tick_cnt, tsel, base;
  note_t notes [$];
  note_t n;
  assign flags = {o_cpu_halt, o_wdt_halt, o_periph_clk_en, o_tbt_clk_en,
    o_fast_osc_en, o_slow_osc_en, o_main_clk_slow, o_div_low_stop,
    o_port_hiz, o_port_in_zero, o_shared_pin_hiz, o_tb_irq_take};
  // ==========================================================
  // design and far side
  operating_mode_controller #(.warm_fast0(warm_tab[0]),
    .warm_fast1(warm_tab[1]), .warm_fast2(warm_tab[2]),
    .warm_fast3(warm_tab[3]), .warm_slow0(warm_tab[4]),
    .warm_slow_run_fastosc_off(warm_tab[5]), .warm_slow_run_fastosc_on(warm_tab[6]),
    .warm_slow3(warm_tab[7])) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_stop_pin(i_stop_pin),
    .i_key_wake(i_key_wake), .i_wake_irq(i_wake_irq),
    .i_tb_taps(i_tb_taps), .i_master_int_en(i_master_int_en),
    .i_tb_irq_en(i_tb_irq_en), .o_cpu_halt(o_cpu_halt),
    .o_wdt_halt(o_wdt_halt), .o_periph_clk_en(o_periph_clk_en),
    .o_tbt_clk_en(o_tbt_clk_en), .o_fast_osc_en(o_fast_osc_en),
    .o_slow_osc_en(o_slow_osc_en), .o_main_clk_slow(o_main_clk_slow),
    .o_div_low_stop(o_div_low_stop), .o_port_hiz(o_port_hiz),
    .o_port_in_zero(o_port_in_zero), .o_shared_pin_hiz(o_shared_pin_hiz),
    .o_tb_irq_set(o_tb_irq_set), .o_tb_irq_take(o_tb_irq_take),
    .o_mcycle_tick(o_mcycle_tick), .o_mode(o_mode));
  wake_side_model #(.pin_delay(3)) far (.i_clk(i_clk),
    .i_pin_level(pin_level), .i_key_level(key_level),
    .i_key_allowed(key_allowed), .o_stop_pin(i_stop_pin),
    .o_key_wake(i_key_wake), .o_taps(i_tb_taps));
  // ==========================================================
  // clock, watchers and comparison
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    tap_hist <= {tap_hist[1:0], i_tb_taps[tsel]};
    if (o_tb_irq_set === 1'b1) irq_cnt <= irq_cnt + 1;
    if (o_mcycle_tick === 1'b1) tick_cnt <= tick_cnt + 1;
  end
  // results are taken at the falling edge, well clear of updates
  always @(negedge i_clk) begin
    if (rd_q === 1'b1 || peek === 1'b1) begin
      n = notes.pop_front();
      seen = n.sel == 0 ? {8'h00, o_rdata} : {4'h0, n.sel == 1 ? o_mode : flags};
      check(n.nm, seen & n.m, n.e);
    end
  end
  task automatic check(string nm, logic [15:0] s, logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // bus and stimulus tasks
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(string nm, logic [15:0] a, logic [7:0] m, logic [7:0] e);
    notes.push_back('{nm, 0, {8'h00, m}, {8'h00, e}});
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic look(string nm, int s, logic [11:0] m, logic [11:0] e);
    notes.push_back('{nm, s, {4'h0, m}, {4'h0, e}});
    @(posedge i_clk);
    peek <= 1'b1;
    @(posedge i_clk);
    peek <= 1'b0;
  endtask
  task automatic wake();
    @(posedge i_clk);
    i_wake_irq <= 1'b1;
    @(posedge i_clk);
    i_wake_irq <= 1'b0;
  endtask
  task automatic wait_mode(logic [11:0] m, int lim);
    int k;
    k = 0;
    while (o_mode !== m && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    check("mode reached", {4'h0, o_mode}, {4'h0, m});
  endtask
  task automatic ticks(int e);
    base = tick_cnt;
    repeat (40) @(posedge i_clk);
    check("machine cycles", 16'(tick_cnt - base), 16'(e));
  endtask
  // one stop entry and release; early raises the pin before entry
  task automatic stop_run(logic release_method_bit, logic return_mode_bit, logic stop_output_hold_bit,
      logic [1:0] warmup_select, logic early, logic key);
    logic [7:0] c;
    int k;
    c = {1'b1, release_method_bit, return_mode_bit, stop_output_hold_bit, warmup_select, 2'b00};
    key_allowed <= release_method_bit;
    pin_level <= early;
    repeat (5) @(posedge i_clk);
    wr(addr_stop_ctrl, c);
    if (!(release_method_bit && early)) begin
      look("stop mode", 1, 12'hfff, stop_mode);
      look("stop flags", 2, 12'hfce, stop_output_hold_bit ? 12'hc02 : 12'hc0e);
      if (early) begin
        repeat (8) @(posedge i_clk);
        look("edge hold", 1, 12'hfff, stop_mode);
        pin_level <= 1'b0;
        repeat (4) @(posedge i_clk);
      end
      if (key) key_level <= 1'b1;
      else pin_level <= 1'b1;
    end
    wait_mode(warmup_mode, 20);
    k = 0;
    while (o_mode === warmup_mode && k < 100) begin
      @(negedge i_clk);
      k++;
    end
    check("warm-up length", 16'(k), 16'(warm_tab[{return_mode_bit, warmup_select}]));
    check("return mode", {4'h0, o_mode}, {4'h0, return_mode_bit ? slow_run_fastosc_off : fast_run_dual});
    rd("stop bit cleared", addr_stop_ctrl, 8'hfc, c & 8'h7c);
    @(posedge i_clk);
    pin_level <= 1'b0;
    key_level <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    logic [7:0] d;
    {i_rst_n, i_wr, i_rd, i_wake_irq, peek, pin_level, key_level} = '0;
    {i_ce, i_tb_irq_en, i_master_int_en} = 3'b111;
    {key_allowed, tap_hist, rd_q, tsel, irq_cnt, tick_cnt} = '0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    void'($urandom(32'ha85e));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    look("reset mode", 1, 12'hfff, fast_run_single);
    look("reset flags", 2, 12'hfff, 12'h380);
    rd("stop ctrl reset", addr_stop_ctrl, 8'hfc, 8'h00);
    rd("clock ctrl reset", addr_clk_ctrl, 8'hff, 8'h80);
    rd("tb ctrl reset", addr_tb_ctrl, 8'hff, 8'h00);
    rd("unmapped", 16'h0040, 8'hff, 8'h00);
    i_ce <= 1'b0;
    wr(addr_clk_ctrl, 8'h00);
    i_ce <= 1'b1;
    rd("frozen write", addr_clk_ctrl, 8'hff, 8'h80);
    d = 8'($urandom) & 8'h7c;
    wr(addr_stop_ctrl, d);
    rd("stop ctrl fields", addr_stop_ctrl, 8'hfc, d);
    wr(addr_clk_ctrl, 8'hc0);
    look("fast dual", 1, 12'hfff, fast_run_dual);
    ticks(10);
    wr(addr_clk_ctrl, 8'hd0);
    look("fast idle", 1, 12'hfff, fast_idle_dual);
    look("fast idle flags", 2, 12'hfff, 12'hfc0);
    ticks(0);
    wake();
    look("fast idle exit", 1, 12'hfff, fast_run_dual);
    rd("idle bit cleared", addr_clk_ctrl, 8'hff, 8'hc0);
    wr(addr_clk_ctrl, 8'he0);
    wr(addr_clk_ctrl, 8'hf0);
    look("slow idle on", 1, 12'hfff, slow_idle_fastosc_on);
    look("slow idle on flags", 2, 12'hfff, 12'hfe0);
    repeat ($urandom_range(9, 2)) @(posedge i_clk);
    wake();
    look("slow idle on exit", 1, 12'hfff, slow_run_fastosc_on);
    wr(addr_clk_ctrl, 8'h60);
    look("slow off flags", 2, 12'hfff, 12'h370);
    wr(addr_clk_ctrl, 8'h70);
    look("slow idle off", 1, 12'hfff, slow_idle_fastosc_off);
    look("slow idle off flags", 2, 12'hfff, 12'hf70);
    wake();
    look("slow idle off exit", 1, 12'hfff, slow_run_fastosc_off);
    rd("idle bit cleared", addr_clk_ctrl, 8'hff, 8'h60);
    for (int s = 0; s < 4; s++) begin
      tsel = s;
      i_master_int_en <= (s != 3);
      wr(addr_tb_ctrl, {s[0], 5'h00, 2'(s)});
      base = 0;
      while (tap_hist[1:0] !== 2'b10 && base < 300) begin
        @(negedge i_clk);
        base++;
      end
      wr(addr_clk_ctrl, 8'h64);
      look("gated mode", 1, 12'hfff, gated_slow_idle);
      look("gated flags", 2, 12'hfff, 12'hd70 | 12'(s == 1));
      base = irq_cnt;
      wait_mode(slow_run_fastosc_off, 300);
      check("tap fall", {14'h0, tap_hist[1:0]}, 16'h0002);
      repeat (4) @(posedge i_clk);
      check("irq latch", 16'(irq_cnt - base), 16'(s % 2));
      rd("halt bit cleared", addr_clk_ctrl, 8'hff, 8'h60);
    end
    wr(addr_clk_ctrl, 8'he0);
    wr(addr_clk_ctrl, 8'hc0);
    stop_run(1'b0, 1'b0, 1'b0, 2'd0, 1'b1, 1'b0);
    stop_run(1'b1, 1'b0, 1'b1, 2'd1, 1'b1, 1'b0);
    wr(addr_clk_ctrl, 8'he0);
    wr(addr_clk_ctrl, 8'h60);
    stop_run(1'b0, 1'b1, 1'b1, 2'd2, 1'b0, 1'b0);
    stop_run(1'b1, 1'b1, 1'b0, 2'd3, 1'b0, 1'b1);
    key_allowed <= 1'b0;
    wr(addr_stop_ctrl, 8'ha0);
    look("stop before reset", 1, 12'hfff, stop_mode);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    look("reset out of stop", 1, 12'hfff, fast_run_single);
    look("flags after reset", 2, 12'hfff, 12'h380);
    rd("clock ctrl after", addr_clk_ctrl, 8'hff, 8'h80);
    repeat (4) @(posedge i_clk);
    conclude();
  end
endmodule
